// [rtl/lcdsm_pkg.sv]
/*
 Package for the segment memory and bias control block: register offsets,
 field positions, reset values and sizes.
 Assumes an 8-bit special function register port on a single system clock.
*/
package lcdsm_pkg;
  // Register offsets in the special function space
  localparam logic [7:0] ADDR_MAIN_CONFIG = 8'h95;
  localparam logic [7:0] ADDR_SEG_EN_LOW = 8'h97;
  localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h96;
  localparam logic [7:0] ADDR_VOLT_CONFIG = 8'h9C;
  localparam logic [7:0] ADDR_MEM_POINTER = 8'hAC;
  localparam logic [7:0] ADDR_MEM_DATA = 8'hAE;
  localparam logic [7:0] ADDR_UPDATE_CONFIG = 8'hB1;
  localparam logic [7:0] ADDR_SEG_EN_HIGH = 8'hED;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hF4;
  // Field positions
  localparam int MAIN_ENABLE_POS = 7;
  localparam int MAIN_CLEAR_POS = 6;
  localparam int MAIN_PSM_OFF_POS = 4;
  localparam int MAIN_MUX_LSB = 0;
  localparam int VOLT_EXT_POS = 6;
  localparam int PTR_WRITE_POS = 7;
  localparam int UPD_FREEZE_POS = 0;
  localparam int PERIPHERAL_REF_POS = 3;
  // Field values and sizes
  localparam logic [1:0] MUX_THREE = 2'h2;
  localparam logic [1:0] MUX_FOUR = 2'h3;
  localparam logic [3:0] FRAME_DIV_64HZ = 4'hF;
  localparam int MEM_DEPTH = 15;
  localparam logic [5:0] MEM_LAST = 6'h0E;
  localparam int SEG_LINES = 29;
  localparam int FIXED_SEGS = 16;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_SEG_EN_HIGH = 8'h00;
endpackage

// [rtl/lcdsm_ctrl.sv]
/*
 Segment memory, voltage source and display gating for the segment display
 driver. Assumes the core issues single-cycle register reads and writes on
 clk_sys with stable address and data; read data is registered one cycle.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Contract
// - Pointer write with top bit clear loads data register from memory.
// - Fifteen bytes; byte n holds lines 2n low, 2n+1 high; 0x0E line 28.
// - Nibble bit k is the segment state for common line k.
// - Source select bit 6 resets to charge pump; one picks resistor ladder.
// - With ladder selected, bias level does not affect drive levels.
// - Charge pump with display disabled switches voltage generation off.
// - Six-bit bias level field gives 64 contrast levels for the pump.
// - Deep power-save display on only if disable bit 0 and enable 1.
// - Configuration and memory kept unchanged while display off.
// - Segment pins 0 to 15 always active; shared pins need enables. Code: only 16..25 use enables; 26 is fixed on and 27..28 go by mux.
// - Four-way multiplexing makes pins 28 and 27 common lines only.
// - 2048 Hz clock, four-way mux, all divider bits one gives 64 Hz.
// - Pointer write with top bit set stores data register into memory.
// - Freeze bit holds the displayed pattern; clearing it applies updates.
// - Mux 10 makes pin 28 common two; 11 also pin 27 common three.
// - Memory clear bit or power-on reset zeroes every memory byte; a pointer store in the clear cycle still writes its byte.
module lcdsm_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic deep_powersave_mode,
  output logic [7:0] sfr_rdata,
  output logic [115:0] display_pattern,
  output logic [28:0] segment_line_active,
  output logic [3:0] common_line_active,
  output logic display_on,
  output logic pump_enable,
  output logic ladder_select,
  output logic [5:0] contrast_bias_level,
  output logic [3:0] frame_divider,
  output logic refresh_64hz
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] display_main_config, next_display_main_config;
  logic [7:0] display_clock_config, next_display_clock_config;
  logic [7:0] segment_pin_enable_low, next_segment_pin_enable_low;
  logic [7:0] display_voltage_config, next_display_voltage_config;
  logic [7:0] segment_memory_pointer, next_segment_memory_pointer;
  logic [7:0] segment_memory_data, next_segment_memory_data;
  logic [7:0] display_update_config, next_display_update_config;
  logic [7:0] segment_pin_enable_high, next_segment_pin_enable_high;
  logic [7:0] peripheral_config, next_peripheral_config;
  logic [7:0] seg_mem [lcdsm_pkg::MEM_DEPTH];
  logic [7:0] next_seg_mem [lcdsm_pkg::MEM_DEPTH];
  logic [7:0] next_sfr_rdata;
  logic [5:0] ptr_idx;
  logic ptr_ok;
  logic ptr_wr;

  assign ptr_wr = sfr_wr && sfr_addr == lcdsm_pkg::ADDR_MEM_POINTER;
  assign ptr_idx = sfr_wdata[5:0];
  assign ptr_ok = ptr_idx <= lcdsm_pkg::MEM_LAST;

  // Register and memory next values; contents change on writes and on the memory clear bit
  always_comb begin
    next_display_main_config = display_main_config;
    next_display_clock_config = display_clock_config;
    next_segment_pin_enable_low = segment_pin_enable_low;
    next_display_voltage_config = display_voltage_config;
    next_segment_memory_pointer = segment_memory_pointer;
    next_segment_memory_data = segment_memory_data;
    next_display_update_config = display_update_config;
    next_segment_pin_enable_high = segment_pin_enable_high;
    next_peripheral_config = peripheral_config;
    next_seg_mem = seg_mem;
    // Clear bit is self-clearing so a later write is not needed
    next_display_main_config[lcdsm_pkg::MAIN_CLEAR_POS] = 1'b0;
    if (display_main_config[lcdsm_pkg::MAIN_CLEAR_POS]) begin
      for (int i = 0; i < lcdsm_pkg::MEM_DEPTH; i++) begin
        next_seg_mem[i] = 8'h00;
      end
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        lcdsm_pkg::ADDR_MAIN_CONFIG:
          next_display_main_config = sfr_wdata;
        lcdsm_pkg::ADDR_CLOCK_CONFIG:
          next_display_clock_config = sfr_wdata;
        lcdsm_pkg::ADDR_SEG_EN_LOW:
          next_segment_pin_enable_low = sfr_wdata;
        lcdsm_pkg::ADDR_VOLT_CONFIG:
          next_display_voltage_config = sfr_wdata;
        lcdsm_pkg::ADDR_MEM_DATA:
          next_segment_memory_data = sfr_wdata;
        lcdsm_pkg::ADDR_UPDATE_CONFIG:
          next_display_update_config = sfr_wdata;
        lcdsm_pkg::ADDR_SEG_EN_HIGH:
          next_segment_pin_enable_high = {4'h0, sfr_wdata[3:0]};
        lcdsm_pkg::ADDR_PERIPHERAL_CONFIG:
          next_peripheral_config = sfr_wdata;
        lcdsm_pkg::ADDR_MEM_POINTER: begin
          next_segment_memory_pointer = {sfr_wdata[7], 1'b0, ptr_idx};
          // Same-cycle transfer so the next instruction sees it
          if (ptr_ok && sfr_wdata[lcdsm_pkg::PTR_WRITE_POS]) begin
            next_seg_mem[ptr_idx[3:0]] = segment_memory_data;
            if (ptr_idx == lcdsm_pkg::MEM_LAST) begin
              next_seg_mem[ptr_idx[3:0]][7:4] = 4'h0;
            end
          end else if (ptr_ok) begin
            next_segment_memory_data = seg_mem[ptr_idx[3:0]];
          end
        end
        default: ;
      endcase
    end
  end

  // Register update; reset acts as power-on clear of the memory
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      display_main_config <= lcdsm_pkg::RST_REG;
      display_clock_config <= lcdsm_pkg::RST_REG;
      segment_pin_enable_low <= lcdsm_pkg::RST_REG;
      display_voltage_config <= lcdsm_pkg::RST_REG;
      segment_memory_pointer <= lcdsm_pkg::RST_REG;
      segment_memory_data <= lcdsm_pkg::RST_REG;
      display_update_config <= lcdsm_pkg::RST_REG;
      segment_pin_enable_high <= lcdsm_pkg::RST_SEG_EN_HIGH;
      peripheral_config <= lcdsm_pkg::RST_REG;
      for (int i = 0; i < lcdsm_pkg::MEM_DEPTH; i++) begin
        seg_mem[i] <= 8'h00;
      end
    end else begin
      display_main_config <= next_display_main_config;
      display_clock_config <= next_display_clock_config;
      segment_pin_enable_low <= next_segment_pin_enable_low;
      display_voltage_config <= next_display_voltage_config;
      segment_memory_pointer <= next_segment_memory_pointer;
      segment_memory_data <= next_segment_memory_data;
      display_update_config <= next_display_update_config;
      segment_pin_enable_high <= next_segment_pin_enable_high;
      peripheral_config <= next_peripheral_config;
      seg_mem <= next_seg_mem;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets answer zero
  always_comb begin
    next_sfr_rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        lcdsm_pkg::ADDR_MAIN_CONFIG: next_sfr_rdata = display_main_config;
        lcdsm_pkg::ADDR_CLOCK_CONFIG: next_sfr_rdata = display_clock_config;
        lcdsm_pkg::ADDR_SEG_EN_LOW: next_sfr_rdata = segment_pin_enable_low;
        lcdsm_pkg::ADDR_VOLT_CONFIG: next_sfr_rdata = display_voltage_config;
        lcdsm_pkg::ADDR_MEM_POINTER: next_sfr_rdata = segment_memory_pointer;
        lcdsm_pkg::ADDR_MEM_DATA: next_sfr_rdata = segment_memory_data;
        lcdsm_pkg::ADDR_UPDATE_CONFIG:
          next_sfr_rdata = display_update_config;
        lcdsm_pkg::ADDR_SEG_EN_HIGH:
          next_sfr_rdata = segment_pin_enable_high;
        lcdsm_pkg::ADDR_PERIPHERAL_CONFIG:
          next_sfr_rdata = peripheral_config;
        default: next_sfr_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display control decode
  logic disp_en, psm_off, ext_sel, freeze, ref_en;
  logic [1:0] mux;
  logic next_display_on, next_pump_enable;
  logic [28:0] next_seg_active;
  logic [3:0] next_com_active;
  logic [115:0] live_pattern, next_display_pattern;

  assign disp_en = display_main_config[lcdsm_pkg::MAIN_ENABLE_POS];
  assign psm_off = display_main_config[lcdsm_pkg::MAIN_PSM_OFF_POS];
  assign mux = display_main_config[lcdsm_pkg::MAIN_MUX_LSB +: 2];
  assign ext_sel = display_voltage_config[lcdsm_pkg::VOLT_EXT_POS];
  assign freeze = display_update_config[lcdsm_pkg::UPD_FREEZE_POS];
  assign ref_en = peripheral_config[lcdsm_pkg::PERIPHERAL_REF_POS];

  // Per line: nibble bit k is common line k
  genvar g;
  generate
    for (g = 0; g < lcdsm_pkg::SEG_LINES; g++) begin : g_line
      assign live_pattern[4*g +: 4] =
        seg_mem[g/2][4*(g%2) +: 4];
    end
  endgenerate

  always_comb begin
    // Deep power-save needs reference on and the bit table honoured
    if (deep_powersave_mode) begin
      next_display_on = disp_en && !psm_off && ref_en;
    end else begin
      next_display_on = disp_en;
    end
    next_pump_enable = next_display_on && !ext_sel;
    next_display_pattern = freeze ? display_pattern : live_pattern;
    // Lines 0..15 and 26 fixed on, 27..28 on unless mux takes them; 16..25 follow their enable bits
    next_seg_active = {3'h7,
                       segment_pin_enable_low[5:0],
                       segment_pin_enable_high[3:0],
                       {lcdsm_pkg::FIXED_SEGS{1'b1}}};
    next_com_active = 4'h3;
    if (mux == lcdsm_pkg::MUX_THREE || mux == lcdsm_pkg::MUX_FOUR) begin
      next_seg_active[28] = 1'b0;
      next_com_active[2] = 1'b1;
    end
    if (mux == lcdsm_pkg::MUX_FOUR) begin
      next_seg_active[27] = 1'b0;
      next_com_active[3] = 1'b1;
    end
  end

  // Output registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      display_on <= 1'b0;
      pump_enable <= 1'b0;
      display_pattern <= '0;
      segment_line_active <= '0;
      common_line_active <= 4'h0;
      ladder_select <= 1'b0;
      contrast_bias_level <= 6'h00;
      frame_divider <= 4'h0;
      refresh_64hz <= 1'b0;
    end else begin
      sfr_rdata <= next_sfr_rdata;
      display_on <= next_display_on;
      pump_enable <= next_pump_enable;
      display_pattern <= next_display_pattern;
      segment_line_active <= next_seg_active;
      common_line_active <= next_com_active;
      ladder_select <= ext_sel;
      contrast_bias_level <= display_voltage_config[5:0];
      frame_divider <= display_clock_config[3:0];
      refresh_64hz <= mux == lcdsm_pkg::MUX_FOUR &&
        display_clock_config[3:0] == lcdsm_pkg::FRAME_DIV_64HZ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_ptr_read_data: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ptr_wr && ptr_ok && !sfr_wdata[7] ##1 sfr_rd && sfr_addr ==
    lcdsm_pkg::ADDR_MEM_DATA |=> sfr_rdata == $past(seg_mem[ptr_idx[3:0]], 2))
    else $error("pointer read data wrong");
  a_ptr_write_mem: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ptr_wr && sfr_wdata[7] && sfr_wdata[5:0] < 6'h0E &&
    !display_main_config[6] |=> seg_mem[$past(sfr_wdata[3:0])] ==
    $past(segment_memory_data))
    else $error("pointer write lost");
  a_pump_off_disabled: assert property (@(posedge clk_sys)
    disable iff (sys_rst) !disp_en ##1 !disp_en |=> !pump_enable)
    else $error("pump runs while display disabled");
  a_ladder_no_pump: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ext_sel ##1 ext_sel |=> !pump_enable)
    else $error("pump runs with ladder");
  a_psm_display_gate: assert property (@(posedge clk_sys)
    disable iff (sys_rst) deep_powersave_mode && psm_off |=> !display_on)
    else $error("display on despite power-save disable");
  a_mux_four_pins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mux == lcdsm_pkg::MUX_FOUR |=> common_line_active == 4'hF &&
    segment_line_active[28:27] == 2'b00)
    else $error("four-way pins not common");
  a_fixed_segments: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst |=> segment_line_active[15:0] == 16'hFFFF)
    else $error("fixed segment line off");
  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    freeze |=> display_pattern == $past(display_pattern))
    else $error("pattern changed while frozen");
  a_mem_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    display_main_config[6] && !ptr_wr |=> seg_mem[0] == 8'h00 &&
    seg_mem[14] == 8'h00)
    else $error("memory not cleared");
  a_rate_64hz: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mux == lcdsm_pkg::MUX_FOUR && display_clock_config[3:0] == 4'hF
    |=> refresh_64hz)
    else $error("64 Hz flag missing");
  a_mux_three_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mux == lcdsm_pkg::MUX_THREE |=> common_line_active == 4'h7 &&
    segment_line_active[28:27] == 2'b01)
    else $error("three-way pin not common");
  a_volt_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst |=> {ladder_select, contrast_bias_level} ==
    $past(display_voltage_config[6:0]))
    else $error("voltage config not applied");
  a_pump_needs_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pump_enable |-> display_on && !ladder_select)
    else $error("pump on while off or ladder");

endmodule

// [bench/lcdsm_core_model.sv]
/*
 Core model: issues special function register writes and reads.
 Assumes one clk_sys; the bench calls its tasks in sequence.
*/
`timescale 1ns/1ps
module lcdsm_core_model (
  input wire logic clk_sys,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  // Idle bus at time zero
  initial begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
  end

  // One-cycle write; released lines show junk, never the last value
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask

  // Read data lands on the edge that takes the strobe
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    #1;
    d = sfr_rdata;
  endtask
endmodule

// [bench/lcd_segment_mem_bias_ctrl_test.sv]
/*
 Self-checking bench for the segment memory and bias control block.
 Assumes lcdsm_pkg and lcdsm_core_model are compiled first.
*/
`timescale 1ns/1ps
module lcd_segment_mem_bias_ctrl_test;
  logic clk_sys, sys_rst, sfr_wr, sfr_rd, deep_powersave_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, d;
  logic [115:0] display_pattern, old_pat;
  logic [28:0] segment_line_active;
  logic [3:0] common_line_active, frame_divider;
  logic display_on, pump_enable, ladder_select, refresh_64hz;
  logic [5:0] contrast_bias_level, en_lo;
  logic [3:0] en_hi;
  logic [31:0] lfsr_state;
  logic [7:0] mem [15];
  int bad_count = 0;
  int cmp_count = 0;

  lcdsm_ctrl u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .deep_powersave_mode(deep_powersave_mode),
    .sfr_rdata(sfr_rdata), .display_pattern(display_pattern),
    .segment_line_active(segment_line_active),
    .common_line_active(common_line_active), .display_on(display_on),
    .pump_enable(pump_enable), .ladder_select(ladder_select),
    .contrast_bias_level(contrast_bias_level),
    .frame_divider(frame_divider), .refresh_64hz(refresh_64hz));
  lcdsm_core_model u_core (.clk_sys(clk_sys), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));

  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Random bytes from a shift register, fixed start
  function automatic logic [7:0] rnd();
    lfsr_state = {lfsr_state[30:0],
      lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state[7:0];
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Outputs trail register writes by one edge
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr_mem(input int n, input logic [7:0] v);
    u_core.sfr_write(lcdsm_pkg::ADDR_MEM_DATA, v);
    u_core.sfr_write(lcdsm_pkg::ADDR_MEM_POINTER, 8'h80 | n[7:0]);
  endtask

  task automatic rd_mem(input int n, output logic [7:0] v);
    u_core.sfr_write(lcdsm_pkg::ADDR_MEM_POINTER, n[7:0]);
    u_core.sfr_read(lcdsm_pkg::ADDR_MEM_DATA, v);
  endtask

  // Whole memory against the model, one byte at a time
  task automatic chk_mem();
    for (int n = 14; n >= 0; n--) begin
      rd_mem(n, rd);
      chk(rd, mem[n]);
    end
  endtask

  // Two segment lines per byte; last byte only its low nibble
  function automatic logic [115:0] pat();
    logic [115:0] p;
    for (int n = 0; n < 14; n++) p[8*n+:8] = mem[n];
    p[115:112] = mem[14][3:0];
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("timeout");
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    deep_powersave_mode = 1'b0;
    lfsr_state = 32'hFABA;
    for (int n = 0; n < 15; n++) mem[n] = 8'h00;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    chk(segment_line_active, {3'h7, 10'h000, 16'hFFFF});
    chk(common_line_active, 4'h3);
    chk(ladder_select, 1'b0);
    u_core.sfr_read(8'h00, rd);
    chk(rd, 8'h00);
    chk_mem();
    $display("test reset done");
    // Random fill, then a store past the last byte is ignored
    for (int n = 0; n < 15; n++) begin
      d = rnd();
      mem[n] = (n == 14) ? {4'h0, d[3:0]} : d;
      wr_mem(n, d);
    end
    wr_mem(15, 8'h5A);
    u_core.sfr_write(lcdsm_pkg::ADDR_MEM_POINTER, 8'hCF);
    u_core.sfr_read(lcdsm_pkg::ADDR_MEM_POINTER, rd);
    chk(rd, 8'h8F);
    chk_mem();
    settle();
    chk(display_pattern, pat());
    $display("test memory done");
    // Frozen pattern until software releases it
    old_pat = pat();
    u_core.sfr_write(lcdsm_pkg::ADDR_UPDATE_CONFIG, 8'h01);
    d = rnd();
    mem[3] = ~d;
    wr_mem(3, ~d);
    settle();
    chk(display_pattern, old_pat);
    u_core.sfr_write(lcdsm_pkg::ADDR_UPDATE_CONFIG, 8'h00);
    settle();
    chk(display_pattern, pat());
    $display("test freeze done");
    // Shared pin enables and every multiplex code
    d = rnd();
    en_lo = d[5:0];
    u_core.sfr_write(lcdsm_pkg::ADDR_SEG_EN_LOW, {2'h0, en_lo});
    d = rnd();
    en_hi = d[3:0];
    u_core.sfr_write(lcdsm_pkg::ADDR_SEG_EN_HIGH, {4'hF, en_hi});
    u_core.sfr_read(lcdsm_pkg::ADDR_SEG_EN_HIGH, rd);
    chk(rd, {4'h0, en_hi});
    u_core.sfr_write(lcdsm_pkg::ADDR_CLOCK_CONFIG, 8'h0F);
    for (int m = 0; m < 4; m++) begin
      u_core.sfr_write(lcdsm_pkg::ADDR_MAIN_CONFIG, m[7:0]);
      settle();
      chk(segment_line_active, {m < 2, m < 3, 1'b1, en_lo, en_hi,
        16'hFFFF});
      chk(common_line_active, m == 3 ? 4'hF : m == 2 ? 4'h7 : 4'h3);
      chk(refresh_64hz, m == 3);
    end
    chk(frame_divider, 4'hF);
    // Divider 0xE, one short of all ones, must drop the 64 Hz flag
    u_core.sfr_write(lcdsm_pkg::ADDR_CLOCK_CONFIG, 8'h0E);
    settle();
    chk({refresh_64hz, frame_divider}, 5'h0E);
    $display("test pins done");
    // Voltage source, contrast and pump gating
    u_core.sfr_write(lcdsm_pkg::ADDR_VOLT_CONFIG, 8'h2E);
    settle();
    chk({ladder_select, contrast_bias_level}, 7'h2E);
    chk(pump_enable, 1'b0);
    u_core.sfr_write(lcdsm_pkg::ADDR_MAIN_CONFIG, 8'h83);
    settle();
    chk({display_on, pump_enable}, 2'h3);
    u_core.sfr_write(lcdsm_pkg::ADDR_VOLT_CONFIG, 8'h6E);
    settle();
    chk({ladder_select, pump_enable}, 2'h2);
    u_core.sfr_write(lcdsm_pkg::ADDR_VOLT_CONFIG, 8'h2E);
    $display("test voltage done");
    // Deep power-save: reference off first, then the bit table
    @(posedge clk_sys);
    deep_powersave_mode <= 1'b1;
    settle();
    chk(display_on, 1'b0);
    u_core.sfr_write(lcdsm_pkg::ADDR_PERIPHERAL_CONFIG, 8'h08);
    for (int i = 0; i < 4; i++) begin
      u_core.sfr_write(lcdsm_pkg::ADDR_MAIN_CONFIG,
        {i[0], 2'h0, i[1], 4'h3});
      settle();
      chk({display_on, pump_enable}, {2{i == 1}});
    end
    chk_mem();
    u_core.sfr_read(lcdsm_pkg::ADDR_VOLT_CONFIG, rd);
    chk(rd, 8'h2E);
    $display("test powersave done");
    // Memory clear bit wipes every byte and clears itself
    u_core.sfr_write(lcdsm_pkg::ADDR_MAIN_CONFIG, 8'h40);
    for (int n = 0; n < 15; n++) mem[n] = 8'h00;
    chk_mem();
    u_core.sfr_read(lcdsm_pkg::ADDR_MAIN_CONFIG, rd);
    chk(rd, 8'h00);
    $display("test clear done");
    final_report();
  end
endmodule
